// *** inc/hub_port_cfg_defs.vh ***
// constants for the hub port configuration register bank
`ifndef HUB_PORT_CFG_DEFS_VH
`define HUB_PORT_CFG_DEFS_VH

// register offsets
`define ADDR_FIXED_DEVICE 8'h09
`define ADDR_OFF_LOCAL 8'h0a
`define ADDR_OFF_UPSTREAM 8'h0b
`define ADDR_UP_CURRENT 8'h0c

// field positions
`define BIT_PORT1 1
`define BIT_PORT2 2
`define BIT_FORCED_ONE 3

// forced bit patterns of the maps
`define FIXED_MAP_AND 8'h06
`define FIXED_MAP_OR 8'h08
`define OFF_UP_AND 8'hf6
`define OFF_UP_OR 8'h08

// reset values
`define RST_FIXED_DEVICE 8'h08
`define RST_OFF_LOCAL 8'h08
`define RST_OFF_UPSTREAM 8'h08
`define RST_UP_CURRENT 8'h32
`define CURRENT_LIMIT 8'h32

`endif

// *** hdl/hub_port_cfg.v ***
// hub port configuration register bank and active port renumbering
`timescale 1ns/10ps
`default_nettype none
`include "hub_port_cfg_defs.vh"

module hub_port_cfg (
    input wire CLK_SYS_IN,
    input wire RSTN_IN,
    input wire CFG_WR_IN,
    input wire [7:0] CFG_ADDR_IN,
    input wire [7:0] CFG_WDATA_IN,
    output reg [7:0] CFG_RDATA_OUT,
    input wire INTERNAL_DEFAULT_IN,
    input wire STRAP_LOAD_IN,
    input wire [1:0] FIXED_DEVICE_STRAP_PINS_IN,
    input wire [1:0] PORT_OFF_STRAP_PINS_IN,
    input wire PORT_RENUMBER_SELECT_IN,
    input wire SELF_POWERED_IN,
    output reg [1:0] PORT_AVAILABLE_OUT,
    output reg [1:0] PORT_COUNT_OUT,
    output reg [1:0] PORT1_PHYS_OUT,
    output reg [1:0] PORT2_PHYS_OUT,
    output reg [1:0] FIXED_ACTIVE_OUT,
    output reg COMPOUND_OUT,
    output reg [7:0] UPSTREAM_CURRENT_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, a change counts when stages two and three agree

    // the four strap pins are gathered so one loop filters them all
    wire [3:0] pins_raw;
    wire [3:0] strap;

    assign pins_raw = {PORT_OFF_STRAP_PINS_IN, FIXED_DEVICE_STRAP_PINS_IN};

    // each pin has its own chain, so a slow edge on one pin never holds back another
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin_sync
            reg stage1;
            reg stage2;
            reg stage3;
            reg settled;

            // only stage two reads stage one; the settled value waits for two agreeing samples
            always @(posedge CLK_SYS_IN) begin
                if (!RSTN_IN) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                    stage3 <= 1'b0;
                    settled <= 1'b0;
                end else begin
                    stage1 <= pins_raw[gi];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        settled <= stage3;
                    end
                end
            end

            // a pin that keeps bouncing simply leaves the last settled level in place
            assign strap[gi] = settled;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // forced bits applied on every load; only the upstream map keeps its reserved high bits as written

    function [7:0] fix_map;
        input [7:0] raw;
        input [7:0] and_mask;
        input [7:0] or_mask;
        begin
            fix_map = (raw & and_mask) | or_mask;
        end
    endfunction

    function [7:0] port_bits;
        input [1:0] pins;
        begin
            port_bits = {5'h00, pins, 1'b0};
        end
    endfunction

    reg [7:0] fixed_device_port_map;
    reg [7:0] port_off_map_local_supply;
    reg [7:0] port_off_map_upstream_supply;
    reg [7:0] local_supply_upstream_current;

    ////////////////////////////////////////////////////////////////////////////////
    // write decode

    // one offset compare shared by all the write strobes
    function hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    wire strap_load;
    wire wr_fixed;
    wire wr_off_local;
    wire wr_off_up;
    wire wr_current;

    // strap load overrides bus writes; straps only act in internal default mode
    assign strap_load = INTERNAL_DEFAULT_IN && STRAP_LOAD_IN;
    assign wr_fixed = CFG_WR_IN && hit(CFG_ADDR_IN, `ADDR_FIXED_DEVICE);
    assign wr_off_local = CFG_WR_IN && hit(CFG_ADDR_IN, `ADDR_OFF_LOCAL);
    assign wr_off_up = CFG_WR_IN && hit(CFG_ADDR_IN, `ADDR_OFF_UPSTREAM);
    assign wr_current = CFG_WR_IN && hit(CFG_ADDR_IN, `ADDR_UP_CURRENT);

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers, one process each

    // fixed device map: ports 1 and 2 in bits 1 and 2, every other bit forced
    // forcing on load keeps read back and the status logic in agreement
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            fixed_device_port_map <= `RST_FIXED_DEVICE;
        end else if (strap_load) begin
            fixed_device_port_map <= fix_map(port_bits(strap[1:0]),
                `FIXED_MAP_AND, `FIXED_MAP_OR);
        end else if (wr_fixed) begin
            fixed_device_port_map <= fix_map(CFG_WDATA_IN,
                `FIXED_MAP_AND, `FIXED_MAP_OR);
        end
    end

    // disable map for local supply operation
    // the strap pins feed both disable maps, so a supply change keeps the same ports off
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            port_off_map_local_supply <= `RST_OFF_LOCAL;
        end else if (strap_load) begin
            port_off_map_local_supply <= fix_map(port_bits(strap[3:2]),
                `FIXED_MAP_AND, `FIXED_MAP_OR);
        end else if (wr_off_local) begin
            port_off_map_local_supply <= fix_map(CFG_WDATA_IN,
                `FIXED_MAP_AND, `FIXED_MAP_OR);
        end
    end

    // disable map for upstream supply operation
    // reserved high bits are kept as written, only bits 3 and 0 are forced
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            port_off_map_upstream_supply <= `RST_OFF_UPSTREAM;
        end else if (strap_load) begin
            port_off_map_upstream_supply <= fix_map(port_bits(strap[3:2]),
                `OFF_UP_AND, `OFF_UP_OR);
        end else if (wr_off_up) begin
            port_off_map_upstream_supply <= fix_map(CFG_WDATA_IN,
                `OFF_UP_AND, `OFF_UP_OR);
        end
    end

    // upstream current in 2 mA units, stored as written with no clamp
    // a strap load still blocks the write so a load cycle takes no bus data
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            local_supply_upstream_current <= `RST_UP_CURRENT;
        end else if (wr_current && !strap_load) begin
            local_supply_upstream_current <= CFG_WDATA_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read back, unmapped offsets read zero

    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            CFG_RDATA_OUT <= 8'h00;
        end else begin
            case (CFG_ADDR_IN)
                `ADDR_FIXED_DEVICE: CFG_RDATA_OUT <= fixed_device_port_map;
                `ADDR_OFF_LOCAL: CFG_RDATA_OUT <= port_off_map_local_supply;
                `ADDR_OFF_UPSTREAM: CFG_RDATA_OUT <= port_off_map_upstream_supply;
                `ADDR_UP_CURRENT: CFG_RDATA_OUT <= local_supply_upstream_current;
                default: CFG_RDATA_OUT <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // port status towards the hub core

    reg [1:0] off_sel;
    reg [1:0] avail;
    reg [1:0] next_count;
    reg [1:0] next_p1;
    reg [1:0] next_p2;

    // physical port behind a logical number; available ports are packed from the bottom
    function [1:0] phys_of;
        input [1:0] live;
        input which;
        begin
            case ({which, live})
                3'h1: phys_of = 2'h1;
                3'h2: phys_of = 2'h2;
                3'h3: phys_of = 2'h1;
                3'h7: phys_of = 2'h2;
                default: phys_of = 2'h0;
            endcase
        end
    endfunction

    // remap mode hands port numbering to a separate assignment, so the disable maps are ignored there
    always @* begin
        // the map that applies follows the supply the hub runs from right now
        off_sel = SELF_POWERED_IN ?
            port_off_map_local_supply[`BIT_PORT2:`BIT_PORT1] :
            port_off_map_upstream_supply[`BIT_PORT2:`BIT_PORT1];
        // in standard numbering a set disable bit removes the port outright
        avail = PORT_RENUMBER_SELECT_IN ? 2'b11 : ~off_sel;
        next_count = {1'b0, avail[0]} + {1'b0, avail[1]};
        // logical port 1 is the lowest available physical port, 0 means none
        next_p1 = phys_of(avail, 1'b0);
        next_p2 = phys_of(avail, 1'b1);
    end

    // availability: a disabled port stays off until its map, the supply or the mode changes
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            PORT_AVAILABLE_OUT <= 2'b00;
        end else begin
            PORT_AVAILABLE_OUT <= avail;
        end
    end

    // number of ports the host is told about
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            PORT_COUNT_OUT <= 2'd0;
        end else begin
            PORT_COUNT_OUT <= next_count;
        end
    end

    // physical port behind logical port 1
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            PORT1_PHYS_OUT <= 2'd0;
        end else begin
            PORT1_PHYS_OUT <= next_p1;
        end
    end

    // physical port behind logical port 2, only present when both ports are live
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            PORT2_PHYS_OUT <= 2'd0;
        end else begin
            PORT2_PHYS_OUT <= next_p2;
        end
    end

    // only flags, no descriptor data: the attached device answers for itself
    // a fixed flag on a disabled port is dropped so the host never sees a dead port
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            FIXED_ACTIVE_OUT <= 2'b00;
        end else begin
            FIXED_ACTIVE_OUT <= fixed_device_port_map[`BIT_PORT2:`BIT_PORT1] & avail;
        end
    end

    // compound is set in internal default mode once any port is fixed; outside that mode it stays low
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            COMPOUND_OUT <= 1'b0;
        end else begin
            COMPOUND_OUT <= INTERNAL_DEFAULT_IN &&
                (fixed_device_port_map[`BIT_PORT2:`BIT_PORT1] != 2'b00);
        end
    end

    // upstream current as reported to the host
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            UPSTREAM_CURRENT_OUT <= 8'h00;
        end else begin
            UPSTREAM_CURRENT_OUT <= local_supply_upstream_current;
        end
    end

endmodule // hub_port_cfg
`default_nettype wire

// *** verif/hub_port_cfg_chk.sv ***
// concurrent checks on the hub port configuration bank
`timescale 1ns/10ps
`default_nettype none
module hub_port_cfg_chk (
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    input wire logic CFG_WR_IN,
    input wire logic [7:0] CFG_ADDR_IN,
    input wire logic [7:0] CFG_WDATA_IN,
    input wire logic [7:0] CFG_RDATA_OUT,
    input wire logic INTERNAL_DEFAULT_IN,
    input wire logic PORT_RENUMBER_SELECT_IN,
    input wire logic SELF_POWERED_IN,
    input wire logic [1:0] PORT_AVAILABLE_OUT,
    input wire logic [1:0] PORT_COUNT_OUT,
    input wire logic [1:0] PORT1_PHYS_OUT,
    input wire logic [1:0] FIXED_ACTIVE_OUT,
    input wire logic [7:0] UPSTREAM_CURRENT_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RSTN_IN);
    // local map write, then one quiet self-powered cycle in standard mode
    sequence s_local_wr;
        CFG_WR_IN && CFG_ADDR_IN == 8'h0a && !INTERNAL_DEFAULT_IN ##1 SELF_POWERED_IN
            && !PORT_RENUMBER_SELECT_IN && !CFG_WR_IN && !INTERNAL_DEFAULT_IN;
    endsequence
    // forced bits, counts and ordering of the live ports
    a_fixed_forced: assert property (CFG_ADDR_IN == 8'h09 |=>
        (CFG_RDATA_OUT & 8'hf9) == 8'h08) else $error("fixed map forced bits");
    a_upmap_forced: assert property (CFG_ADDR_IN == 8'h0b |=>
        (CFG_RDATA_OUT & 8'h09) == 8'h08) else $error("upstream map forced bits");
    a_count_sum: assert property (PORT_COUNT_OUT ==
        {1'b0, PORT_AVAILABLE_OUT[0]} + {1'b0, PORT_AVAILABLE_OUT[1]}) else $error("port count");
    a_first_phys: assert property (PORT1_PHYS_OUT == (PORT_AVAILABLE_OUT[0] ? 2'h1 :
        {PORT_AVAILABLE_OUT[1], 1'b0})) else $error("first logical port");
    a_remap_all: assert property (PORT_RENUMBER_SELECT_IN |=>
        PORT_AVAILABLE_OUT == 2'h3) else $error("remap mode availability");
    a_fixed_live: assert property ((FIXED_ACTIVE_OUT & ~PORT_AVAILABLE_OUT) == 2'h0)
        else $error("fixed flag on dead port");
    a_current_copy: assert property (CFG_WR_IN && CFG_ADDR_IN == 8'h0c && !INTERNAL_DEFAULT_IN
        |=> ##1 UPSTREAM_CURRENT_OUT == $past(CFG_WDATA_IN, 2)) else $error("current value");
    a_local_map: assert property (s_local_wr |=>
        PORT_AVAILABLE_OUT == ~$past(CFG_WDATA_IN[2:1], 2)) else $error("local map");
endmodule // hub_port_cfg_chk
bind hub_port_cfg hub_port_cfg_chk chk (.*);
`default_nettype wire

// *** verif/cfg_host.sv ***
// behavioural configuring party writing and reading configuration bytes
`timescale 1ns/10ps
`default_nettype none
module cfg_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    // idle bus
    initial begin
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // one byte; data is scrambled after release so stale values never look valid
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= (a == 8'h0c && d > 8'h32) ? 8'h32 : d;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~wdata;
    endtask
    // read data arrives one cycle after the offset
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 d = rdata;
    endtask
endmodule // cfg_host
`default_nettype wire

// *** verif/hub_port_config_registers_bench.sv ***
// self-checking bench for the hub port configuration bank
`timescale 1ns/10ps
`default_nettype none
module hub_port_config_registers_bench;
    logic CLK_SYS_IN, RSTN_IN, INTERNAL_DEFAULT_IN, STRAP_LOAD_IN, SELF_POWERED_IN;
    logic PORT_RENUMBER_SELECT_IN;
    logic [1:0] FIXED_DEVICE_STRAP_PINS_IN, PORT_OFF_STRAP_PINS_IN;
    wire logic CFG_WR_IN, COMPOUND_OUT;
    wire logic [7:0] CFG_ADDR_IN, CFG_WDATA_IN, CFG_RDATA_OUT, UPSTREAM_CURRENT_OUT;
    wire logic [1:0] PORT_AVAILABLE_OUT, PORT_COUNT_OUT, PORT1_PHYS_OUT, PORT2_PHYS_OUT;
    wire logic [1:0] FIXED_ACTIVE_OUT;
    wire logic [7:0] ports = {PORT_COUNT_OUT, PORT1_PHYS_OUT, PORT2_PHYS_OUT, PORT_AVAILABLE_OUT};
    int fails = 0, samples_checked = 0, cycles = 0;
    hub_port_cfg uut (.*);
    cfg_host host (.clk(CLK_SYS_IN), .rdata(CFG_RDATA_OUT), .wr(CFG_WR_IN), .addr(CFG_ADDR_IN),
        .wdata(CFG_WDATA_IN));
    // 20 MHz clock
    initial begin
        CLK_SYS_IN = 1'b0;
        forever #25 CLK_SYS_IN = ~CLK_SYS_IN;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.get(a, d);
        chk(d, exp);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic test_regs;
        host.put(8'h09, 8'hff);
        host.put(8'h0b, 8'hff);
        host.put(8'h0c, 8'h2a);
        rd(8'h09, 8'h0e);
        rd(8'h0b, 8'hfe);
        rd(8'h0d, 8'h00);
        chk(UPSTREAM_CURRENT_OUT, 8'h2a);
        chk({7'h00, COMPOUND_OUT}, 8'h00);
        $display("regs done");
    endtask
    task automatic test_maps;
        host.put(8'h0a, 8'h04);
        repeat (2) @(posedge CLK_SYS_IN);
        #1 chk(ports, 8'h51);
        host.put(8'h0a, 8'h02);
        repeat (2) @(posedge CLK_SYS_IN);
        #1 chk(ports, 8'h62);
        @(posedge CLK_SYS_IN);
        SELF_POWERED_IN <= 1'b0;
        repeat (2) @(posedge CLK_SYS_IN);
        #1 chk(ports, 8'h00);
        @(posedge CLK_SYS_IN);
        PORT_RENUMBER_SELECT_IN <= 1'b1;
        repeat (2) @(posedge CLK_SYS_IN);
        #1 chk(ports, 8'h9b);
        @(posedge CLK_SYS_IN);
        PORT_RENUMBER_SELECT_IN <= 1'b0;
        SELF_POWERED_IN <= 1'b1;
        $display("maps done");
    endtask
    // straps need four edges through the filter before a load
    task automatic test_straps;
        @(posedge CLK_SYS_IN);
        INTERNAL_DEFAULT_IN <= 1'b1;
        FIXED_DEVICE_STRAP_PINS_IN <= 2'h1;
        PORT_OFF_STRAP_PINS_IN <= 2'h2;
        repeat (5) @(posedge CLK_SYS_IN);
        STRAP_LOAD_IN <= 1'b1;
        @(posedge CLK_SYS_IN);
        STRAP_LOAD_IN <= 1'b0;
        repeat (2) @(posedge CLK_SYS_IN);
        #1 chk(ports, 8'h51);
        chk({6'h0, FIXED_ACTIVE_OUT}, 8'h01);
        chk({7'h00, COMPOUND_OUT}, 8'h01);
        rd(8'h09, 8'h0a);
        $display("straps done");
    endtask
    // hang guard
    always @(posedge CLK_SYS_IN) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        {RSTN_IN, INTERNAL_DEFAULT_IN, STRAP_LOAD_IN, PORT_RENUMBER_SELECT_IN} = 4'h0;
        SELF_POWERED_IN = 1'b1;
        FIXED_DEVICE_STRAP_PINS_IN = 2'h0;
        PORT_OFF_STRAP_PINS_IN = 2'h0;
        repeat (12) @(posedge CLK_SYS_IN);
        RSTN_IN <= 1'b1;
        test_regs;
        test_maps;
        test_straps;
        finish_test;
    end
endmodule // hub_port_config_registers_bench
`default_nettype wire
